// ---- hdl/afp_pkg.sv ----
// Shared constants and types for the amplifier fault supervisor.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package afp_pkg;

   // Clock rate in kHz; keeps the retry product inside 32 bits
   localparam int CLK_KHZ = 100_000;
   // Channel retry interval after an output short, in ms
   localparam int RETRY_MS = 50;
   // Retry interval in clock cycles
   localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;

   // Status byte field positions
   localparam int OFFSET_ALARM_POS = 2;
   localparam int SHORT_POS        = 3;
   // Instruction byte field positions
   localparam int FAULT_FLAG_PIN_MASK_POS    = 7;
   localparam int PROT_DIS_POS     = 7;
   // Instruction bytes after power-on reset
   localparam logic [7:0] INSTR_RST = 8'h00;
   // Status bytes after reset
   localparam logic [7:0] STATUS_RST = 8'h00;

   // Amplifier start-up state, Gray coded along the start-up path
   typedef enum logic [1:0] {
      AMP_OFF    = 2'h0,
      AMP_WINCHK = 2'h1,
      AMP_MUTE   = 2'h3,
      AMP_RUN    = 2'h2
   } afp_amp_t;

   // Channel retry state; code 2'h2 is illegal
   typedef enum logic [1:0] {
      CH_RUN  = 2'h0,
      CH_OFF  = 2'h1,
      CH_WAIT = 2'h3
   } afp_chan_t;

endpackage

// ---- hdl/afp_chan_retry.sv ----
// One channel's short-circuit switch-off, retry timer and window hold.
// Assumes short indications are synchronous to clock.
`timescale 1ns/1ps
module afp_chan_retry #(
   parameter int RETRY_CYC = afp_pkg::RETRY_CYC
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic loadShort,
   input  wire logic supplyShort,
   output logic      chanRun,
   output logic      chanFault
);
   localparam int CW = $clog2(RETRY_CYC + 1);
   localparam logic [CW-1:0] LOAD = CW'(RETRY_CYC);

   if (RETRY_CYC < 2) begin : g_chk
      $error("RETRY_CYC must be at least 2");
   end

   afp_pkg::afp_chan_t state_q, state_d;   // Channel state
   logic [CW-1:0]      cnt_q, cnt_d;       // Retry countdown
   logic               shortPrev_q;        // Short level last cycle

   wire shortAny = loadShort | supplyShort;
   wire newEvent = shortAny & ~shortPrev_q;

   // State, counter and edge history
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_q     <= afp_pkg::CH_RUN;
         cnt_q       <= '0;
         shortPrev_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         shortPrev_q <= shortAny;
      end
   end

   // Switch off, count down, retry; a lasting load short trips again at once
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         afp_pkg::CH_RUN: begin
            if (shortAny) begin
               state_d = afp_pkg::CH_OFF;
               cnt_d   = LOAD;
            end
         end
         afp_pkg::CH_OFF: begin
            if (newEvent) begin
               cnt_d = LOAD;
            end else if (cnt_q == CW'(1)) begin
               // Supply short keeps the channel parked
               state_d = supplyShort ? afp_pkg::CH_WAIT : afp_pkg::CH_RUN;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
         afp_pkg::CH_WAIT: begin
            if (!supplyShort) begin
               state_d = afp_pkg::CH_RUN;
            end
         end
         default: state_d = afp_pkg::CH_RUN;
      endcase
   end

   assign chanRun   = (state_q == afp_pkg::CH_RUN);
   assign chanFault = ~chanRun;

   chk_retry_hold: assert property (@(posedge clock) disable iff (!nrst)
      state_q == afp_pkg::CH_OFF && !newEvent && cnt_q > CW'(1)
      |=> state_q == afp_pkg::CH_OFF)
      else $error("channel left off state early");
   chk_window_block: assert property (@(posedge clock) disable iff (!nrst)
      state_q == afp_pkg::CH_WAIT && supplyShort |=> !chanRun)
      else $error("channel restarted into supply short");
   chk_retry_restart: assert property (@(posedge clock) disable iff (!nrst)
      state_q == afp_pkg::CH_OFF && newEvent |=> cnt_q == LOAD)
      else $error("retry timer not restarted on new short");

endmodule // afp_chan_retry

// ---- hdl/afp_supervisor.sv ----
// Fault supervisor: protection decisions, start-up window check, offset
// latch, sticky status and the two open-drain flag pins.
// Assumes all comparator flags and bus-engine strobes are synchronous to
// clock; the serial bus engine delivers instruction bytes and read strobes.
`timescale 1ns/1ps
// Contract
// - Foldback lowers gain; higher threshold shuts down
// - Overtemperature shuts power stage immediately
// - Overcurrent limits current, never shuts down
// - Load short: channel off, retry every 50 ms
// - Supply short blocks restart until removed
// - Start-up halts while outputs read shorted
// - Offset guard active in mute and operating
// - Offset sets alarm; pin unless masked
// - Offset latches full shutdown unless disabled
// - Standalone offset always flags and shuts down
// - Grounded filter pin disables offset guard
// - Low supply: mute, stop, auto restart
// - High supply shuts power stages
// - Deep drop resets; bus command restarts
// - Channel or whole-amp scope; offset latched
// - Flag pins only pull low
// - Short pulls fault pin, sets sticky bits
// - Read returns latched then refreshes
// - Fault pin releases when fault clears
// - Bus mode pin mapping, some selectable
// - Standalone pin mapping fixed
// - Offset mask and disable reset zero
module afp_supervisor #(
   parameter int RETRY_CYC = afp_pkg::RETRY_CYC
) (
   input  wire logic       clock,
   input  wire logic       nrst,
   // Mode and control pins
   input  wire logic       busMode,
   input  wire logic       enable,
   input  wire logic       muteSelect,
   input  wire logic       deepDrop,
   // Comparator flags
   input  wire logic       tempFoldback,
   input  wire logic       tempShutdown,
   input  wire logic       overTemp,
   input  wire logic [1:0] overCurrent,
   input  wire logic [1:0] loadShort,
   input  wire logic [1:0] supplyShort,
   input  wire logic       outputsShorted,
   input  wire logic       offsetDetect,
   input  wire logic       offsetFilterCap,
   input  wire logic       lowSupply,
   input  wire logic       highSupply,
   input  wire logic       clipDetect,
   input  wire logic       tempPrewarn,
   input  wire logic       clipSelect,
   input  wire logic       prewarnSelect,
   // Serial bus engine side
   input  wire logic [7:0] instrByte1,
   input  wire logic [7:0] instrByte2,
   input  wire logic       instrWrite,
   input  wire logic       statusRead,
   // Amplifier controls
   output logic            gainReduce,
   output logic [1:0]      currentLimit,
   output logic [1:0]      chanOn,
   output logic            switchingOn,
   output logic            muted,
   output logic            startHalted,
   // Status bytes and flag pins
   output logic [7:0]      statusByte1,
   output logic [7:0]      statusByte2,
   output logic            faultFlagO,
   output logic            faultFlagOeN,
   output logic            clipFlagO,
   output logic            clipFlagOeN
);
   if (RETRY_CYC < 2) begin : g_chk
      $error("RETRY_CYC must be at least 2");
   end

   // Build a status byte from its sticky fields
   function automatic logic [7:0] mkStatus(input logic shortBit,
                                           input logic alarmBit);
      logic [7:0] b;
      b = afp_pkg::STATUS_RST;
      b[afp_pkg::SHORT_POS]        = shortBit;
      b[afp_pkg::OFFSET_ALARM_POS] = alarmBit;
      return b;
   endfunction

   // Registers
   logic [7:0]        instr1_q, instr2_q;     // Held instruction bytes
   logic              porFlag_q, porFlag_d;   // Power-on reset pending
   afp_pkg::afp_amp_t ampState_q, ampState_d; // Start-up state
   logic              enablePrev_q;           // Enable level last cycle
   logic              offsetShut_q, offsetShut_d; // Latched offset stop
   logic              alarm_q, alarm_d;       // Sticky offset alarm
   logic [1:0]        short_q, short_d;       // Sticky short bits
   logic [7:0]        status1_q, status2_q;   // Bytes handed to reader
   logic              faultOeN_q, clipOeN_q;  // Pin enables, low drives

   // Per-channel retry results
   logic [1:0] chanRun;                       // Channel may switch
   logic [1:0] chanFault;                     // Channel parked by short

   // Decoded control
   // Mask and disable act live from the held bytes
   wire diagMask = instr1_q[afp_pkg::FAULT_FLAG_PIN_MASK_POS];
   wire protDis  = instr2_q[afp_pkg::PROT_DIS_POS];
   wire switching = (ampState_q == afp_pkg::AMP_MUTE) |
                    (ampState_q == afp_pkg::AMP_RUN);
   // Guard only sees offsets while outputs switch
   wire guardEn   = offsetFilterCap & switching;
   wire offsetHit = guardEn & offsetDetect;
   // Any change of enable counts as a toggle
   wire enToggle  = enable ^ enablePrev_q;
   // Standalone mode ignores the disable bit
   wire offsetTrip = offsetHit & (~busMode | ~protDis);
   wire offsetClr  = enToggle | (busMode & protDis) | ~offsetFilterCap;
   wire tempStop   = overTemp | tempShutdown;
   // Whole-amplifier stop terms
   wire ampStop = tempStop | highSupply | offsetShut_q | porFlag_q |
                  ~enable;
   // Any parked channel shows on the fault pin
   wire anyShort = |chanFault;

   // Channel retry engines
   for (genvar i = 0; i < 2; i++) begin : g_chan
      afp_chan_retry #(
         .RETRY_CYC   (RETRY_CYC)
      ) u_retry (
         .clock       (clock),
         .nrst        (nrst),
         .loadShort   (loadShort[i]),
         .supplyShort (supplyShort[i]),
         .chanRun     (chanRun[i]),
         .chanFault   (chanFault[i])
      );
   end

   // Instruction bytes; a deep drop acts as power-on reset in bus mode
   always_ff @(posedge clock) begin
      if (!nrst || (deepDrop && busMode)) begin
         instr1_q <= afp_pkg::INSTR_RST;
         instr2_q <= afp_pkg::INSTR_RST;
      end else if (instrWrite) begin
         instr1_q <= instrByte1;
         instr2_q <= instrByte2;
      end
   end

   // Reset pending: set by drop, cleared by a bus command
   always_comb begin
      porFlag_d = porFlag_q;
      if (deepDrop && busMode) begin
         porFlag_d = 1'b1;
      end else if (!busMode || instrWrite) begin
         porFlag_d = 1'b0;
      end
   end

   // Offset latch; a new trip wins over a clear in the same cycle
   assign offsetShut_d = offsetTrip | (offsetShut_q & ~offsetClr);

   // Sticky bits: a read hands over old values and reloads current
   // ones, so a fault present at the read survives it
   assign short_d = statusRead ? chanFault : (short_q | chanFault);
   assign alarm_d = statusRead ? (offsetHit & busMode) :
                    (alarm_q | (offsetHit & busMode));

   // Start-up and supply sequencing
   always_comb begin
      ampState_d = ampState_q;
      unique case (ampState_q)
         afp_pkg::AMP_OFF: begin
            // Automatic restart once every stop term has gone
            if (!ampStop && !lowSupply) begin
               ampState_d = afp_pkg::AMP_WINCHK;
            end
         end
         afp_pkg::AMP_WINCHK: begin
            // Power stages still off while outputs are checked
            if (ampStop || lowSupply) begin
               ampState_d = afp_pkg::AMP_OFF;
            end else if (!outputsShorted) begin
               ampState_d = afp_pkg::AMP_MUTE;
            end
         end
         afp_pkg::AMP_MUTE: begin
            // Second step of low supply: stop switching
            if (ampStop || lowSupply) begin
               ampState_d = afp_pkg::AMP_OFF;
            end else if (!muteSelect) begin
               // Unmute once the host lets go of mute
               ampState_d = afp_pkg::AMP_RUN;
            end
         end
         afp_pkg::AMP_RUN: begin
            // Hard stops skip the mute step
            if (ampStop) begin
               ampState_d = afp_pkg::AMP_OFF;
            end else if (lowSupply || muteSelect) begin
               // Low supply mutes first, stop follows
               ampState_d = afp_pkg::AMP_MUTE;
            end
         end
      endcase
   end

   // Pin content; offset pulls the pin while present or latched
   wire offsetShown = (offsetHit | offsetShut_q) &
                      (~busMode | ~diagMask);
   // Fault pin follows live conditions, the reset flag and the latched offset stop
   wire faultNow = porFlag_q | lowSupply | highSupply | anyShort |
                   tempStop | offsetShown;
   // Clip and prewarn items are selectable in bus mode; the reset flag always shows
   wire clipNow = porFlag_q |
                  (clipDetect  & (~busMode | clipSelect)) |
                  (tempPrewarn & (~busMode | prewarnSelect));

   // Control state
   always_ff @(posedge clock) begin
      if (!nrst) begin
         porFlag_q    <= 1'b1;
         ampState_q   <= afp_pkg::AMP_OFF;
         enablePrev_q <= 1'b0;
         offsetShut_q <= 1'b0;
      end else begin
         porFlag_q    <= porFlag_d;
         ampState_q   <= ampState_d;
         enablePrev_q <= enable;
         offsetShut_q <= offsetShut_d;
      end
   end

   // Sticky status and the bytes returned to the reader
   always_ff @(posedge clock) begin
      if (!nrst) begin
         short_q   <= 2'h0;
         alarm_q   <= 1'b0;
         status1_q <= afp_pkg::STATUS_RST;
         status2_q <= afp_pkg::STATUS_RST;
      end else begin
         short_q <= short_d;
         alarm_q <= alarm_d;
         if (statusRead) begin
            status1_q <= mkStatus(short_q[0], alarm_q);
            status2_q <= mkStatus(short_q[1], 1'b0);
         end
      end
   end

   // Open-drain enables, registered so the pins never glitch
   always_ff @(posedge clock) begin
      if (!nrst) begin
         faultOeN_q <= 1'b1;
         clipOeN_q  <= 1'b1;
      end else begin
         faultOeN_q <= ~faultNow;
         clipOeN_q  <= ~clipNow;
      end
   end

   // Outputs
   assign gainReduce   = tempFoldback & switching;
   assign chanOn       = {2{switching}} & chanRun;
   // Limiting leaves the channel switching
   assign currentLimit = overCurrent & chanOn;
   assign switchingOn  = switching;
   assign muted        = (ampState_q == afp_pkg::AMP_MUTE);
   assign startHalted  = (ampState_q == afp_pkg::AMP_WINCHK) &
                         outputsShorted;
   assign statusByte1  = status1_q;
   assign statusByte2  = status2_q;
   // Pins only ever pull low
   assign faultFlagO   = 1'b0;
   assign faultFlagOeN = faultOeN_q;
   assign clipFlagO    = 1'b0;
   assign clipFlagOeN  = clipOeN_q;

   // Assertions

   // Overtemperature parks the whole amplifier
   chk_otp_shutdown: assert property (@(posedge clock) disable iff (!nrst)
      overTemp |=> ampState_q == afp_pkg::AMP_OFF ##1 !switching)
      else $error("overtemperature did not stop amplifier");

   // Load dump stops switching
   chk_high_supply: assert property (@(posedge clock) disable iff (!nrst)
      highSupply |=> !switching)
      else $error("high supply did not stop power stage");

   // Limiting alone never parks a channel
   chk_current_limit: assert property (@(posedge clock) disable iff (!nrst)
      overCurrent[0] && chanOn[0] && !loadShort[0] && !supplyShort[0] &&
      !ampStop && !lowSupply |=> chanOn[0])
      else $error("current limiting stopped channel");

   // Mute first; the stop only follows if low supply lasts
   chk_lowsup_mute: assert property (@(posedge clock) disable iff (!nrst)
      ampState_q == afp_pkg::AMP_RUN && lowSupply && !ampStop
      |=> muted ##1 (!switching || !$past(lowSupply)))
      else $error("low supply did not mute before stopping");

   // Shorted outputs hold start-up
   chk_win_halt: assert property (@(posedge clock) disable iff (!nrst)
      startHalted && !ampStop && !lowSupply |=> !switching)
      else $error("start-up continued into shorted outputs");

   // Offset stop stays until a documented release
   chk_offset_latch: assert property (@(posedge clock) disable iff (!nrst)
      offsetShut_q && !enToggle && !(busMode && protDis) && offsetFilterCap
      |=> offsetShut_q)
      else $error("offset shutdown released without cause");

   // Alarm bit follows every bus-mode offset
   chk_offset_alarm: assert property (@(posedge clock) disable iff (!nrst)
      busMode && offsetHit && !statusRead |=> alarm_q)
      else $error("offset alarm not set");

   // Standalone offset always latches and flags
   chk_sa_offset: assert property (@(posedge clock) disable iff (!nrst)
      !busMode && offsetHit |=> offsetShut_q && !faultFlagOeN)
      else $error("standalone offset not latched and flagged");

   // No restart before the host's command
   chk_por_hold: assert property (@(posedge clock) disable iff (!nrst)
      porFlag_q && busMode && !instrWrite |=> porFlag_q && !switching)
      else $error("amplifier left reset without bus command");

   // Parked channel pulls the fault pin
   chk_short_pin: assert property (@(posedge clock) disable iff (!nrst)
      anyShort |=> !faultFlagOeN)
      else $error("short not shown on fault pin");

   // Pin lets go as soon as the fault is gone
   chk_fault_release: assert property (@(posedge clock) disable iff (!nrst)
      !faultNow |=> faultFlagOeN)
      else $error("fault pin held after fault cleared");

   // Unselected clip stays off the pin
   chk_clip_pin: assert property (@(posedge clock) disable iff (!nrst)
      busMode && clipDetect && !clipSelect && !porFlag_q && !tempPrewarn
      |=> clipFlagOeN)
      else $error("unselected clip shown on pin");

endmodule // afp_supervisor

// ---- dv/afp_host_model.sv ----
// Host-side model: resolves the two open-drain flag pins against their
// pull-ups and drives instruction writes and status reads.
// Assumes the supervisor runs on the same clock as this model.
`timescale 1ns/1ps
module afp_host_model (
   input  wire logic       clock,
   input  wire logic [7:0] statusByte1,
   input  wire logic [7:0] statusByte2,
   input  wire logic       faultFlagO,
   input  wire logic       faultFlagOeN,
   input  wire logic       clipFlagO,
   input  wire logic       clipFlagOeN,
   output logic      [7:0] instrByte1,
   output logic      [7:0] instrByte2,
   output logic            instrWrite,
   output logic            statusRead,
   output logic            faultPin,
   output logic            clipPin
);
   // Pull-ups hold each line high unless the device pulls it low
   assign faultPin = faultFlagOeN ? 1'b1 : faultFlagO;
   assign clipPin  = clipFlagOeN ? 1'b1 : clipFlagO;

   // Idle levels at time zero
   initial begin
      instrByte1 = 8'h00;
      instrByte2 = 8'h00;
      instrWrite = 1'b0;
      statusRead = 1'b0;
   end

   // One-cycle write of both instruction bytes; also the restart command
   task automatic write_instr(input logic [7:0] b1, input logic [7:0] b2);
      @(posedge clock);
      instrByte1 <= b1;
      instrByte2 <= b2;
      instrWrite <= 1'b1;
      @(posedge clock);
      instrWrite <= 1'b0;
   endtask

   // One status read; bytes are valid one cycle after the strobe edge
   task automatic read_status(output logic [7:0] b1, output logic [7:0] b2);
      @(posedge clock);
      statusRead <= 1'b1;
      @(posedge clock);
      statusRead <= 1'b0;
      #2;
      b1 = statusByte1;
      b2 = statusByte2;
   endtask
endmodule // afp_host_model

// ---- dv/test_afp_supervisor.sv ----
// Self-checking bench for the fault supervisor.
// Assumes a shortened retry count so channel retries fit a short run.
`timescale 1ns/1ps
module test_afp_supervisor;
   localparam int RETRY = 20; // Shortened retry interval in cycles
   logic clock = 1'b0, nrst = 1'b0, busMode = 1'b1, enable = 1'b1;
   logic muteSelect = 1'b0, deepDrop = 1'b0, tempFoldback = 1'b0;
   logic outputsShorted = 1'b0, offsetDetect = 1'b0, filterCap = 1'b1;
   logic lowSupply = 1'b0, clipDetect = 1'b0, tempPrewarn = 1'b0;
   logic clipSelect = 1'b0, prewarnSelect = 1'b0;
   logic [2:0] stopVec = 3'h0;  // overTemp, tempShutdown, highSupply
   logic [1:0] overCurrent = 2'h0, loadShort = 2'h0, supplyShort = 2'h0;
   logic [7:0] instr1, instr2, sb1, sb2, r1, r2;
   logic       instrWrite, statusRead, gainReduce, switchingOn, muted;
   logic       startHalted, fO, fOeN, cO, cOeN, faultPin, clipPin;
   logic [1:0] currentLimit, chanOn;
   int         failCount = 0, nCompared = 0, n;

   always #5 clock = ~clock; // 100 MHz

   afp_supervisor #(.RETRY_CYC(RETRY)) afp_supervisor_inst (
      .clock(clock), .nrst(nrst), .busMode(busMode), .enable(enable),
      .muteSelect(muteSelect), .deepDrop(deepDrop),
      .tempFoldback(tempFoldback), .tempShutdown(stopVec[1]),
      .overTemp(stopVec[0]), .overCurrent(overCurrent),
      .loadShort(loadShort), .supplyShort(supplyShort),
      .outputsShorted(outputsShorted), .offsetDetect(offsetDetect),
      .offsetFilterCap(filterCap), .lowSupply(lowSupply),
      .highSupply(stopVec[2]), .clipDetect(clipDetect),
      .tempPrewarn(tempPrewarn), .clipSelect(clipSelect),
      .prewarnSelect(prewarnSelect), .instrByte1(instr1),
      .instrByte2(instr2), .instrWrite(instrWrite),
      .statusRead(statusRead), .gainReduce(gainReduce),
      .currentLimit(currentLimit), .chanOn(chanOn),
      .switchingOn(switchingOn), .muted(muted), .startHalted(startHalted),
      .statusByte1(sb1), .statusByte2(sb2), .faultFlagO(fO),
      .faultFlagOeN(fOeN), .clipFlagO(cO), .clipFlagOeN(cOeN));

   afp_host_model afp_host_model_inst (
      .clock(clock), .statusByte1(sb1), .statusByte2(sb2),
      .faultFlagO(fO), .faultFlagOeN(fOeN), .clipFlagO(cO),
      .clipFlagOeN(cOeN), .instrByte1(instr1), .instrByte2(instr2),
      .instrWrite(instrWrite), .statusRead(statusRead),
      .faultPin(faultPin), .clipPin(clipPin));

   // Single comparison point; four-state compare so X never matches
   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Let k edges pass, then sample once everything has settled
   task automatic look(input int k);
      repeat (k) @(posedge clock);
      #2;
   endtask

   // Single place that ends the run
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Bounded wait for the amplifier to reach full operation
   task automatic wait_run();
      for (n = 0; n < 60; n++) begin
         look(1);
         if (switchingOn === 1'b1 && muted === 1'b0 && chanOn === 2'h3)
            return;
      end
      failCount++;
      $display("[FAIL] amplifier never reached operation");
      report_and_stop();
   endtask

   initial begin
      look(16);
      chk("pins in reset", {faultPin, clipPin}, 8'h03);
      @(posedge clock) nrst <= 1'b1;
      look(3);
      // Power-on flag shows on both pins and blocks start in bus mode
      chk("por pins", {faultPin, clipPin}, 8'h00);
      chk("por off", {switchingOn, chanOn}, 8'h00);
      afp_host_model_inst.read_status(r1, r2);
      chk("reset status", {r1, r2}, 8'h00);
      afp_host_model_inst.write_instr(8'h00, 8'h00);
      wait_run();
      chk("run pins", {faultPin, clipPin}, 8'h03);
      $display("test reset done");

      // Foldback lowers gain only; each hard stop parks the whole amp
      @(posedge clock) tempFoldback <= 1'b1;
      look(3);
      chk("foldback", {gainReduce, switchingOn}, 8'h03);
      @(posedge clock) tempFoldback <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         @(posedge clock) stopVec <= 3'h1 << k;
         look(3);
         chk("stop", {switchingOn, chanOn, faultPin}, 8'h00);
         @(posedge clock) stopVec <= 3'h0;
         wait_run();
         look(2);
         chk("stop released", faultPin, 8'h01);
      end
      $display("test temperature and supply stops done");

      // Current limiting keeps both channels switching
      @(posedge clock) overCurrent <= 2'h1;
      look(3);
      chk("limit", {currentLimit, chanOn, faultPin}, 8'h0F);
      @(posedge clock) overCurrent <= 2'h0;

      // Load short on channel 1: only that channel parks, then retries
      @(posedge clock) loadShort <= 2'h1;
      @(posedge clock) loadShort <= 2'h0;
      #2;
      chk("short chan", chanOn, 8'h02);
      look(1);
      chk("short pin", faultPin, 8'h00);
      for (n = 2; n < 100 && chanOn[0] !== 1'b1; n++)
         look(1);
      chk("retry time", (n >= RETRY + 1 && n <= RETRY + 2), 8'h01);
      look(2);
      chk("pin freed", faultPin, 8'h01);
      afp_host_model_inst.read_status(r1, r2);
      chk("sticky", {r1, r2}, 16'h0800);
      afp_host_model_inst.read_status(r1, r2);
      chk("fresh", {r1, r2}, 8'h00);
      $display("test load short done");

      // Supply short on channel 2 holds the channel past the retry time
      @(posedge clock) supplyShort <= 2'h2;
      look(RETRY + 10);
      chk("window hold", chanOn, 8'h01);
      @(posedge clock) supplyShort <= 2'h0;
      wait_run();
      afp_host_model_inst.read_status(r1, r2);
      chk("sticky ch2", {r1, r2}, 16'h0008);
      afp_host_model_inst.read_status(r1, r2);
      chk("fresh ch2", {r1, r2}, 16'h0000);
      $display("test supply short done");

      // Offset in bus mode for every mask and disable combination
      for (int m = 0; m < 4; m++) begin
         afp_host_model_inst.write_instr({m[0], 7'h0}, {m[1], 7'h0});
         @(posedge clock) offsetDetect <= 1'b1;
         look(2);
         @(posedge clock) offsetDetect <= 1'b0;
         look(3);
         chk("offset run", switchingOn, m[1]);
         chk("offset pin", faultPin, (m[0] | m[1]));
         afp_host_model_inst.read_status(r1, r2);
         chk("offset alarm", r1, 8'h04);
         @(posedge clock) enable <= 1'b0;
         @(posedge clock) enable <= 1'b1;
         wait_run();
         afp_host_model_inst.read_status(r1, r2);
      end
      // Grounded filter pin: offset ignored
      @(posedge clock) filterCap <= 1'b0;
      offsetDetect <= 1'b1;
      look(4);
      chk("guard off", {switchingOn, faultPin}, 8'h03);
      @(posedge clock) filterCap <= 1'b1;
      offsetDetect <= 1'b0;
      $display("test bus offset done");

      // Standalone: offset flags and stops despite mask and disable set
      @(posedge clock) busMode <= 1'b0;
      clipDetect <= 1'b1;
      look(3);
      chk("clip fixed", clipPin, 8'h00);
      @(posedge clock) offsetDetect <= 1'b1;
      look(2);
      @(posedge clock) offsetDetect <= 1'b0;
      look(3);
      chk("sa offset", {switchingOn, faultPin}, 8'h00);
      @(posedge clock) enable <= 1'b0;
      busMode <= 1'b1;
      @(posedge clock) enable <= 1'b1;
      look(3);
      chk("clip unselected", clipPin, 8'h01);
      @(posedge clock) clipSelect <= 1'b1;
      look(3);
      chk("clip selected", clipPin, 8'h00);
      @(posedge clock) clipDetect <= 1'b0;
      tempPrewarn <= 1'b1;
      look(3);
      chk("prewarn unselected", clipPin, 8'h01);
      @(posedge clock) tempPrewarn <= 1'b0;
      wait_run();
      $display("test flag mapping done");

      // Low supply mutes first, then stops; start halts on shorted outputs
      @(posedge clock) lowSupply <= 1'b1;
      outputsShorted <= 1'b1;
      look(1);
      chk("low mute", {muted, switchingOn}, 8'h03);
      look(1);
      chk("low stop", {switchingOn, faultPin}, 8'h00);
      @(posedge clock) lowSupply <= 1'b0;
      look(6);
      chk("start halt", {startHalted, switchingOn}, 8'h02);
      @(posedge clock) outputsShorted <= 1'b0;
      wait_run();
      @(posedge clock) muteSelect <= 1'b1;
      look(2);
      chk("mute hold", {muted, switchingOn}, 8'h03);
      @(posedge clock) muteSelect <= 1'b0;
      wait_run();
      $display("test low supply done");

      // Deep drop in bus mode resets; only a bus command restarts
      @(posedge clock) deepDrop <= 1'b1;
      @(posedge clock) deepDrop <= 1'b0;
      look(10);
      chk("drop por", {switchingOn, faultPin, clipPin}, 8'h00);
      afp_host_model_inst.write_instr(8'h00, 8'h00);
      wait_run();
      $display("test deep drop done");
      report_and_stop();
   end
endmodule // test_afp_supervisor
